//--- inc/sci_rx_defines.vh
// Register indices, field positions, reset values and timing counts of the serial receiver
`ifndef SCI_RX_DEFINES_VH
`define SCI_RX_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_BDH       10'h0C2
`define IDX_BDL       10'h0C3
`define IDX_C1        10'h0C4
`define IDX_C2        10'h0C5
`define IDX_C3        10'h0C6
`define IDX_S2        10'h0C7
`define IDX_S1        10'h0C8
`define IDX_D         10'h0C9
`define IDX_CLR       10'h0D8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BDH       8'h00
`define RST_BDL       8'h00
`define RST_C1        8'h0C
`define RST_C2        8'h00
`define RST_C3        8'h00
`define RST_S2        8'h00
`define RST_D         8'hFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BDH_BRK_IE    7
`define BDH_EDGE_IE   6
`define C1_LOOP       7
`define C1_STOP2      6
`define C1_SINGLE     5
`define C1_NINE       4
`define C1_EN         0
`define C2_RXEN       2
`define C2_SLEEP      1
`define C3_TXDIR      5
`define C3_RXINV      3
`define C3_SLPIDLE    2
`define C3_IDLESEL    1
`define C3_WAKE       0
`define S2_BRK_EN     1
`define ST_FULL       0
`define ST_OVR        1
`define ST_NOISE      2
`define ST_IDLE       3
`define ST_BRK        4
`define ST_EDGE       5
`define ST_FRAME      6

// ----------------------------------------------------------------
// Timing counts, in 16x sample ticks and bit times
// ----------------------------------------------------------------
`define OVERSAMPLE    5'd16
`define RT_EARLY_A    5'd3
`define RT_EARLY_B    5'd5
`define RT_EARLY_C    5'd7
`define RT_VOTE_A     5'd8
`define RT_VOTE_B     5'd9
`define RT_VOTE_C     5'd10
`define BREAK_BITS    4'd11
`define IDLE_BITS     4'd10

`endif

//--- src/baud_tick_gen.v
// Divisor counter producing the 16x oversampling tick
`timescale 1ns/1ps
`default_nettype none

module baud_tick_gen #(
    parameter DIV_W = 13
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    input  wire             restart,
    input  wire [DIV_W-1:0] divisor,
    output reg              tick_q
);

    reg  [DIV_W-1:0] cnt_q;
    wire [DIV_W-1:0] cnt_inc = cnt_q + 1'b1;

    // Divisor zero stops the tick; any rewrite restarts the count
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= {DIV_W{1'b0}};
            tick_q <= 1'b0;
        end else if (ce) begin
            if (restart || divisor == {DIV_W{1'b0}}) begin
                cnt_q  <= {DIV_W{1'b0}};
                tick_q <= 1'b0;
            end else if (cnt_inc == divisor) begin
                cnt_q  <= {DIV_W{1'b0}};
                tick_q <= 1'b1;
            end else begin
                cnt_q  <= cnt_inc;
                tick_q <= 1'b0;
            end
        end
    end

endmodule // baud_tick_gen

`default_nettype wire

//--- src/rx_line_select.v
// Pin synchronisers, receive source selection and input inversion
`timescale 1ns/1ps
`default_nettype none

module rx_line_select (
    input  wire clk,
    input  wire rst,
    input  wire ce,
    input  wire rxd_pin,
    input  wire txd_pin_in,
    input  wire tx_serial,
    input  wire loop_en,
    input  wire single_wire,
    input  wire txd_dir_out,
    input  wire invert,
    output reg  rx_q
);

    reg rxd_s1_q;
    reg rxd_s2_q;
    reg txd_s1_q;
    reg txd_s2_q;
    reg src;

    always @* begin
        if (!loop_en) begin
            src = rxd_s2_q;
        end else if (single_wire && !txd_dir_out) begin
            src = txd_s2_q;
        end else begin
            src = tx_serial;
        end
    end

    // Idle line reads high, so synchronisers reset to one
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            txd_s1_q <= 1'b1;
            txd_s2_q <= 1'b1;
            rx_q     <= 1'b1;
        end else if (ce) begin
            rxd_s1_q <= rxd_pin;
            rxd_s2_q <= rxd_s1_q;
            txd_s1_q <= txd_pin_in;
            txd_s2_q <= txd_s1_q;
            rx_q     <= src ^ invert;
        end
    end

endmodule // rx_line_select

`default_nettype wire

//--- src/uart_sci_receiver.v
// APB register file, frame receiver, break, idle and sleep logic of the serial receiver
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sci_rx_defines.vh"

// How it works
// - Invert the serial input first when the invert bit is set.
// - Frame: low start, 8 or 9 data bits LSB first, high stop.
// - Completed character enters the data register and sets full if full was clear.
// - If already full, set overrun and drop the new character.
// - Break counts low bit times, clears on a high, flags at 11-13 bits.
// - Idle armed after first full; counts high bit times, flags at 10-12.
// - Break flag reported only when break detection is enabled.
// - Sample at 16x; falling edge is low after three highs.
// - Start bit checked at phases 3, 5, 7; two lows needed.
// - Each data and stop bit decided by majority of phases 8, 9, 10.
// - Start bit is low once two early samples were low.
// - Any sample disagreeing with its bit sets noise at transfer.
// - Asleep, no flags are set, except idle when its sleep idle enable is on and those of the address wake character.
// - Wake select picks idle or address mark; hardware clears sleep.
// - Idle wake clears sleep on a full idle character.
// - Address wake clears sleep on MSB one; that character sets flags.
// - Internal loopback feeds transmitter output to the receiver.
// - Single wire: direction bit makes the transmit pin input or output.
// - Divisor zero gives no tick; else tick rate is clock over divisor.
// - High divisor register: break enable bit 7, edge bit 6, divisor 4:0.
// - Word length select one gives nine data bits, else eight.
// - Idle count starts after stop bit or after start bit.
module uart_sci_receiver (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rxd_pin,
    input  wire        txd_pin_in,
    input  wire        tx_serial,
    output reg         txd_pin_out,
    output reg         txd_pin_oe
);

    // ----------------------------------------------------------------
    // State encodings
    // ----------------------------------------------------------------
    localparam S_IDLE  = 2'd0;
    localparam S_START = 2'd1;
    localparam S_DATA  = 2'd2;
    localparam S_STOP  = 2'd3;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0] bdh_q;
    reg  [7:0] bdl_q;
    reg  [7:0] c1_q;
    reg  [7:0] c2_q;
    reg  [6:0] c3_q;
    reg  [7:0] s2_q;
    reg  [6:0] st_q;
    reg  [7:0] data_q;
    reg        r8_q;
    reg        armed_q;
    reg  [1:0] state_q;
    reg  [4:0] rt_q;
    reg  [3:0] bit_q;
    reg  [8:0] shreg_q;
    reg  [2:0] hist_q;
    reg  [1:0] early_q;
    reg  [1:0] vote_q;
    reg        noise_q;
    reg  [7:0] low_cnt_q;
    reg  [7:0] high_cnt_q;
    reg        rx_prev_q;

    wire       tick;
    wire       rx;
    wire       div_write;
    wire       wr_en = psel && penable && pready && pwrite;
    wire [9:0] idx   = paddr[11:2];

    wire run       = c1_q[`C1_EN] && c2_q[`C2_RXEN];
    wire nine      = c1_q[`C1_NINE];
    wire sleep     = c2_q[`C2_SLEEP];
    wire [3:0] extra = {3'b000, nine} + {3'b000, c1_q[`C1_STOP2]};
    wire [7:0] brk_thr  = {`BREAK_BITS + extra, 4'b0000};
    wire [7:0] idle_thr = {`IDLE_BITS + extra, 4'b0000};
    wire [3:0] last_bit = nine ? 4'd8 : 4'd7;

    // ----------------------------------------------------------------
    // Sample tick and line input
    // ----------------------------------------------------------------
    assign div_write = wr_en && (idx == `IDX_BDH || idx == `IDX_BDL);

    baud_tick_gen #(
        .DIV_W (13)
    ) u_baud (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .restart (div_write),
        .divisor ({bdh_q[4:0], bdl_q}),
        .tick_q  (tick)
    );

    rx_line_select u_line (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .rxd_pin     (rxd_pin),
        .txd_pin_in  (txd_pin_in),
        .tx_serial   (tx_serial),
        .loop_en     (c1_q[`C1_LOOP]),
        .single_wire (c1_q[`C1_SINGLE]),
        .txd_dir_out (c3_q[`C3_TXDIR]),
        .invert      (c3_q[`C3_RXINV]),
        .rx_q        (rx)
    );

    // ----------------------------------------------------------------
    // Frame events
    // ----------------------------------------------------------------
    wire in_frame  = state_q != S_IDLE;
    wire edge_seen = tick && run && !in_frame && hist_q == 3'b111 && !rx;
    wire majority  = (vote_q[0] & vote_q[1]) | (vote_q[0] & rx) | (vote_q[1] & rx);
    wire disagree  = (vote_q[0] != rx) || (vote_q[1] != rx);
    wire at_vote_c = tick && rt_q == `RT_VOTE_C;
    wire done      = at_vote_c && state_q == S_STOP;
    wire wake_addr = done && sleep && c3_q[`C3_WAKE] && shreg_q[8];
    wire flags_ok  = !sleep || wake_addr;
    wire low_tick  = tick && run && !rx;
    wire high_tick = tick && run && rx;
    wire brk_hit   = low_tick && (low_cnt_q + 8'd1) == brk_thr;
    wire idle_go   = (armed_q || sleep) && (!c3_q[`C3_IDLESEL] || !in_frame);
    wire idle_hit  = high_tick && idle_go && (high_cnt_q + 8'd1) == idle_thr;
    wire hw_wake   = wake_addr || (idle_hit && sleep && !c3_q[`C3_WAKE]);
    wire fall      = run && rx_prev_q && !rx;

    // ----------------------------------------------------------------
    // Status flag next value
    // ----------------------------------------------------------------
    reg [6:0] set_v;
    reg [6:0] clr_v;
    always @* begin
        set_v = 7'h00;
        clr_v = 7'h00;
        if (wr_en && idx == `IDX_CLR) begin
            clr_v = pwdata[6:0];
        end
        if (done && flags_ok) begin
            if (st_q[`ST_FULL]) begin
                set_v[`ST_OVR] = 1'b1;
            end else begin
                set_v[`ST_FULL]  = 1'b1;
                set_v[`ST_NOISE] = noise_q || disagree;
                set_v[`ST_FRAME] = !majority;
            end
        end
        if (brk_hit && s2_q[`S2_BRK_EN] && !sleep) begin
            set_v[`ST_BRK] = 1'b1;
        end
        if (idle_hit && (!sleep || c3_q[`C3_SLPIDLE])) begin
            set_v[`ST_IDLE] = 1'b1;
        end
        if (fall && !sleep) begin
            set_v[`ST_EDGE] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Register file writes and flags
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bdh_q   <= `RST_BDH;
            bdl_q   <= `RST_BDL;
            c1_q    <= `RST_C1;
            c2_q    <= `RST_C2;
            c3_q    <= 7'h00;
            s2_q    <= `RST_S2;
            st_q    <= 7'h00;
            data_q  <= `RST_D;
            r8_q    <= 1'b0;
            armed_q <= 1'b0;
        end else if (ce) begin
            if (wr_en && idx == `IDX_BDH) begin
                bdh_q <= pwdata[7:0] & 8'hDF;
            end else if (wr_en && idx == `IDX_BDL) begin
                bdl_q <= pwdata[7:0];
            end else if (wr_en && idx == `IDX_C1) begin
                c1_q <= pwdata[7:0] & 8'hFD;
            end else if (wr_en && idx == `IDX_C3) begin
                c3_q <= pwdata[6:0];
            end else if (wr_en && idx == `IDX_S2) begin
                s2_q <= pwdata[7:0];
            end
            // Software write to the sleep bit wins over a wake in the same cycle
            if (wr_en && idx == `IDX_C2) begin
                c2_q <= pwdata[7:0];
            end else if (hw_wake) begin
                c2_q[`C2_SLEEP] <= 1'b0;
            end
            // Set beats clear so no event is lost
            st_q <= (st_q & ~clr_v) | set_v;
            if (done && flags_ok && !st_q[`ST_FULL]) begin
                data_q  <= nine ? shreg_q[7:0] : shreg_q[8:1];
                r8_q    <= nine & shreg_q[8];
                armed_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive state machine
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            rt_q    <= 5'd0;
            bit_q   <= 4'd0;
            shreg_q <= 9'h000;
            hist_q  <= 3'b000;
            early_q <= 2'd0;
            vote_q  <= 2'b00;
            noise_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                state_q <= S_IDLE;
                hist_q  <= 3'b000;
            end else if (tick) begin
                hist_q <= {hist_q[1:0], rx};
                rt_q   <= (rt_q == `OVERSAMPLE) ? 5'd1 : rt_q + 5'd1;
                if (rt_q == `RT_VOTE_A) begin
                    vote_q[0] <= rx;
                end
                if (rt_q == `RT_VOTE_B) begin
                    vote_q[1] <= rx;
                end
                case (state_q)
                    S_IDLE: begin
                        if (edge_seen) begin
                            state_q <= S_START;
                            rt_q    <= 5'd2;
                            early_q <= 2'd0;
                            noise_q <= 1'b0;
                        end
                    end
                    S_START: begin
                        // Any high sample from RT3 to RT10 is noise on a low start
                        if (rt_q >= `RT_EARLY_A && rt_q <= `RT_VOTE_C && rx) begin
                            noise_q <= 1'b1;
                        end
                        if ((rt_q == `RT_EARLY_A || rt_q == `RT_EARLY_B) && !rx) begin
                            early_q <= early_q + 2'd1;
                        end
                        if (rt_q == `RT_EARLY_C && early_q == 2'd0) begin
                            state_q <= S_IDLE;
                        end else if (rt_q == `RT_EARLY_C && early_q == 2'd1 && rx) begin
                            state_q <= S_IDLE;
                        end else if (rt_q == `OVERSAMPLE) begin
                            state_q <= S_DATA;
                            bit_q   <= 4'd0;
                        end
                    end
                    S_DATA: begin
                        if (rt_q == `RT_VOTE_C) begin
                            shreg_q <= {majority, shreg_q[8:1]};
                            noise_q <= noise_q | disagree;
                        end
                        if (rt_q == `OVERSAMPLE) begin
                            if (bit_q == last_bit) begin
                                state_q <= S_STOP;
                            end else begin
                                bit_q <= bit_q + 4'd1;
                            end
                        end
                    end
                    default: begin
                        if (rt_q == `RT_VOTE_C) begin
                            state_q <= S_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Break and idle run counters, edge history
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_q  <= 8'd0;
            high_cnt_q <= 8'd0;
            rx_prev_q  <= 1'b1;
        end else if (ce) begin
            rx_prev_q <= rx;
            if (!run || high_tick) begin
                low_cnt_q <= 8'd0;
            end else if (low_tick && low_cnt_q != brk_thr) begin
                low_cnt_q <= low_cnt_q + 8'd1;
            end
            if (!run || low_tick || (tick && !idle_go)) begin
                high_cnt_q <= 8'd0;
            end else if (high_tick && high_cnt_q != idle_thr) begin
                high_cnt_q <= high_cnt_q + 8'd1;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    reg [7:0] rd_v;
    reg       hit_v;
    always @* begin
        rd_v  = 8'h00;
        hit_v = 1'b1;
        if (idx == `IDX_BDH) begin
            rd_v = bdh_q;
        end else if (idx == `IDX_BDL) begin
            rd_v = bdl_q;
        end else if (idx == `IDX_C1) begin
            rd_v = c1_q;
        end else if (idx == `IDX_C2) begin
            rd_v = c2_q;
        end else if (idx == `IDX_C3) begin
            rd_v = {r8_q, c3_q};
        end else if (idx == `IDX_S2) begin
            rd_v = s2_q;
        end else if (idx == `IDX_S1) begin
            rd_v = {1'b0, st_q};
        end else if (idx == `IDX_D) begin
            rd_v = data_q;
        end else if (idx == `IDX_CLR) begin
            rd_v = 8'h00;
        end else begin
            hit_v = 1'b0;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata      <= 32'h00000000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            txd_pin_out <= 1'b1;
            txd_pin_oe  <= 1'b1;
        end else if (ce) begin
            txd_pin_out <= tx_serial;
            // Pin released in loop mode unless single-wire output is selected
            txd_pin_oe  <= c1_q[`C1_LOOP] ? (c1_q[`C1_SINGLE] & c3_q[`C3_TXDIR]) : 1'b1;
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= !hit_v;
                prdata  <= (pwrite || !hit_v) ? 32'h00000000 : {24'h000000, rd_v};
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

endmodule // uart_sci_receiver

`default_nettype wire

//--- verification/uart_rx_monitor.sv
// Concurrent checks on the register bus and transmit pin output of the serial receiver
`timescale 1ns/1ps
`default_nettype none
module uart_rx_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_serial,
    input wire logic        txd_pin_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ------------
    // Bus answer
    // ------------
    sequence access_s;
        psel && penable && !pready && !$past(penable);
    endsequence
    sequence answer_s;
        ##1 pready ##1 !pready;
    endsequence
    ready_timing_a:
        assert property (access_s |-> answer_s) else $error("bus answer mistimed");
    ready_cause_a:
        assert property (pready |-> $past(psel) && $past(penable)) else $error("stray ready");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("ready too long");
    error_ready_a:
        assert property (pslverr |-> pready) else $error("error without ready");
    error_zero_a:
        assert property (pslverr |-> prdata == 32'h0) else $error("data on error");
    write_zero_a:
        assert property (pready && pwrite |-> prdata == 32'h0) else $error("data on write");
    upper_zero_a:
        assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
    // ------------
    // Pin path
    // ------------
    // Reset sampled low first so the reset value of the pin is not judged
    pin_follow_a:
        assert property (!rst |=> txd_pin_out == $past(tx_serial)) else $error("pin lag");
endmodule // uart_rx_monitor
`default_nettype wire

//--- verification/uart_line_model.sv
// Line-side serial transmitter model, sixteen clocks per bit
`timescale 1ns/1ps
`default_nettype none
module uart_line_model (
    input wire logic clk,
    output var logic line
);
    // ------------
    // Frame sender
    // ------------
    initial line = 1'b1;
    // Bit time assumes divisor one; bad adds a one-clock spike mid data bit 3
    task automatic send(input logic [8:0] d, input logic nine, input logic bad);
        logic [10:0] f;
        int          i;
        int          k;
        f = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
        for (i = 0; i < (nine ? 11 : 10); i++) begin
            for (k = 0; k < 16; k++) begin
                line <= f[i] ^ (bad && i == 4 && k == 8);
                @(posedge clk);
            end
        end
    endtask
endmodule // uart_line_model
`default_nettype wire

//--- verification/test_uart_sci_receiver.sv
// Self-checking bench of the serial receiver with a line model on the pins
`timescale 1ns/1ps
`default_nettype none
`include "sci_rx_defines.vh"
module test_uart_sci_receiver;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        inv = 1'b0, brk = 1'b0, mfull = 1'b0, pready, pslverr, e, line;
    logic        rxd_pin, tx_serial, txd_pin_in, txd_pin_out, txd_pin_oe;
    logic [1:0]  route = 2'd0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic [8:0]  d;
    logic [7:0]  md;
    int          err_total = 0, comparisons = 0, i;
    logic [9:0]  ridx [8] = '{`IDX_BDH, `IDX_BDL, `IDX_C1, `IDX_C2, `IDX_C3, `IDX_S2, `IDX_S1, `IDX_D};
    logic [7:0]  rrst [8] = '{`RST_BDH, `RST_BDL, `RST_C1, `RST_C2, `RST_C3, `RST_S2, 8'h00, `RST_D};
    // Unused sources carry the inverted line, so a wrong selection shows
    assign rxd_pin    = brk ? 1'b0 : (route == 2'd0 ? line ^ inv : ~line);
    assign tx_serial  = route == 2'd1 ? line : ~line;
    assign txd_pin_in = route == 2'd2 ? line : ~line;
    uart_sci_receiver uart_sci_receiver_inst (
        .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd_pin(rxd_pin), .txd_pin_in(txd_pin_in), .tx_serial(tx_serial),
        .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe));
    uart_line_model uart_line_model_inst (.clk(clk), .line(line));
    // ------------
    // Tasks
    // ------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int t;
        t = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 9);
        v = prdata;
        e = pslverr;
        if (t >= 9) begin
            err_total++;
            stop_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rm(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] x,
                      input string nm);
        apb(1'b0, idx, 8'h00);
        check(nm, v & {24'hFFFFFF, m}, {24'h0, x});
    endtask
    // Model keeps the first character while full, later ones are lost
    task automatic rx(input logic [8:0] dd, input logic nine, input logic g, input logic clr);
        if (clr) begin
            apb(1'b1, `IDX_CLR, 8'hFF);
            mfull = 1'b0;
        end
        uart_line_model_inst.send(dd, nine, g);
        if (!mfull) md = dd[7:0];
        mfull = 1'b1;
    endtask
    initial forever #20 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
    // ------------
    // Main sequence
    // ------------
    initial begin
        void'($urandom(61583));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 8; i++) rm(ridx[i], 8'hFF, rrst[i], "reset value");
        apb(1'b0, 10'h0D0, 8'h00);
        check("unmapped error", e, 1);
        apb(1'b1, `IDX_BDH, 8'hFF);
        rm(`IDX_BDH, 8'hFF, 8'hDF, "high divisor");
        apb(1'b1, `IDX_BDH, 8'h00);
        apb(1'b1, `IDX_C1, 8'h01);
        apb(1'b1, `IDX_C2, 8'h04);
        rx(9'h055, 1'b0, 1'b0, 1'b1);
        rm(`IDX_S1, 8'h07, 8'h00, "no baud tick");
        apb(1'b1, `IDX_BDL, 8'h01);
        rx({1'b0, 8'($urandom)}, 1'b0, 1'b0, 1'b1);
        rm(`IDX_S1, 8'h07, 8'h01, "first char");
        rm(`IDX_D, 8'hFF, md, "data");
        rx({1'b0, 8'($urandom)}, 1'b0, 1'b0, 1'b0);
        rm(`IDX_S1, 8'h07, 8'h03, "overrun");
        rm(`IDX_D, 8'hFF, md, "kept data");
        repeat (240) @(posedge clk);
        rm(`IDX_S1, 8'h08, 8'h08, "idle");
        apb(1'b1, `IDX_CLR, 8'h0A);
        rm(`IDX_S1, 8'h07, 8'h01, "partial clear");
        rx({1'b0, 8'($urandom)}, 1'b0, 1'b1, 1'b1);
        rm(`IDX_S1, 8'h07, 8'h05, "noise");
        rm(`IDX_D, 8'hFF, md, "voted data");
        apb(1'b1, `IDX_CLR, 8'hFF);
        brk <= 1'b1;
        repeat (3) @(posedge clk);
        brk <= 1'b0;
        repeat (300) @(posedge clk);
        rm(`IDX_S1, 8'h07, 8'h00, "false start");
        for (i = 0; i < 2; i++) begin
            apb(1'b1, `IDX_S2, i[0] ? 8'h02 : 8'h00);
            apb(1'b1, `IDX_CLR, 8'hFF);
            brk <= 1'b1;
            repeat (240) @(posedge clk);
            brk <= 1'b0;
            repeat (20) @(posedge clk);
            rm(`IDX_S1, 8'h50, i[0] ? 8'h50 : 8'h40, "break");
        end
        apb(1'b1, `IDX_C1, 8'h11);
        d = {1'b1, 8'($urandom)};
        rx(d, 1'b1, 1'b0, 1'b1);
        rm(`IDX_D, 8'hFF, md, "nine bit data");
        rm(`IDX_C3, 8'h80, 8'h80, "ninth bit");
        apb(1'b1, `IDX_C1, 8'h01);
        apb(1'b1, `IDX_C3, 8'h08);
        inv <= 1'b1;
        repeat (300) @(posedge clk);
        rx({1'b0, 8'($urandom)}, 1'b0, 1'b0, 1'b1);
        rm(`IDX_D, 8'hFF, md, "inverted");
        apb(1'b1, `IDX_C3, 8'h01);
        inv <= 1'b0;
        repeat (300) @(posedge clk);
        apb(1'b1, `IDX_C2, 8'h06);
        rx(9'h012, 1'b0, 1'b0, 1'b1);
        rm(`IDX_S1, 8'h07, 8'h00, "asleep");
        rx(9'h085, 1'b0, 1'b0, 1'b1);
        rm(`IDX_S1, 8'h07, 8'h01, "address wake");
        rm(`IDX_C2, 8'hFF, 8'h04, "sleep cleared");
        apb(1'b1, `IDX_C3, 8'h00);
        apb(1'b1, `IDX_C2, 8'h06);
        repeat (200) @(posedge clk);
        rm(`IDX_C2, 8'hFF, 8'h04, "idle wake");
        route <= 2'd1;
        apb(1'b1, `IDX_C1, 8'h81);
        repeat (300) @(posedge clk);
        rx({1'b0, 8'($urandom)}, 1'b0, 1'b0, 1'b1);
        rm(`IDX_D, 8'hFF, md, "loopback");
        check("loop oe", txd_pin_oe, 0);
        route <= 2'd2;
        apb(1'b1, `IDX_C1, 8'hA1);
        repeat (300) @(posedge clk);
        rx({1'b0, 8'($urandom)}, 1'b0, 1'b0, 1'b1);
        rm(`IDX_D, 8'hFF, md, "single wire");
        check("input oe", txd_pin_oe, 0);
        apb(1'b1, `IDX_C3, 8'h20);
        @(posedge clk);
        check("output oe", txd_pin_oe, 1);
        stop_test();
    end
endmodule // test_uart_sci_receiver
bind uart_sci_receiver uart_rx_monitor uart_rx_monitor_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_serial(tx_serial), .txd_pin_out(txd_pin_out));
`default_nettype wire
